// >>> core/dclc_clock_control.sv
// Overview of operation
// [R01] run mode clocks master from divided clock
// [R02] can clock selectable, watchdog on oscillator
// [R03] run gating vector gates master peripherals
// [R04] gating applies only to enabled peripherals
// [R05] wfi stops cpu, enters sleep or deep
// [R06] enabled interrupt returns master to run
// [R07] sleep stops master cpu and memory
// [R08] sleep gating: run or sleep vector
// [R09] sleep peripheral rate equals run rate
// [R10] sleep-after-isr re-enters the same mode
// [R11] deep sleep stops plls, analog, control
// [R12] deep gating: run or deep vector
// [R13] deep source: slow, fast or oscillator
// [R14] deep source divided twice for peripherals
// [R15] oscillator off when internal deep source
// [R16] master checks control standby before deep; code enters deep on wfi without checking ctrl_mode
// [R17] control records standby entry in status
// [R18] pll register ownership request and reclaim
// [R19] control peripherals gated per gating vector
// [R20] control core and peripheral clocks produced
// [R21] normal, idle, standby control clock states
// [R22] timer two clock from selected source divided
// [R23] low and high speed prescaled clocks
// [R24] idle status plus mode bits pick mode
// [R25] missing clock substitutes fast clock, flags
// [R26] idle ends on interrupt or nmi
// [R27] standby wake qualified by sample field
// [R28] clock switching without truncated pulses
`timescale 1ns/10ps
`default_nettype none
module dclc_clock_control #(
  parameter int NPER = 8,
  parameter int NCAN = 2,
  parameter int NCP = 16,
  parameter int DIV_W = 4,
  parameter int PRE_W = 3,
  parameter int MISS_LIMIT = dclc_pkg::DCLC_MISS_LIMIT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // source clock pins
  input wire logic pll_clk_in,
  input wire logic osc_clk_a,
  input wire logic aux_clk_in,
  input wire logic slow_internal_clk,
  input wire logic fast_internal_clk,
  // master configuration
  input wire logic [NPER-1:0] run_gating_cfg,
  input wire logic [NPER-1:0] sleep_gating_cfg,
  input wire logic [NPER-1:0] deep_sleep_gating_cfg,
  input wire logic [NPER-1:0] device_config_enable,
  input wire logic auto_gating_select,
  input wire logic [DIV_W-1:0] master_clk_divider,
  input wire logic [1:0] deep_sleep_src_sel,
  input wire logic [DIV_W-1:0] deep_sleep_div,
  input wire logic [2*NCAN-1:0] can_clk_sel,
  // master core events
  input wire logic wait_for_interrupt_instr,
  input wire logic deep_sleep_select,
  input wire logic sleep_on_exit,
  input wire logic master_wake_irq,
  input wire logic master_isr_done,
  // pll register ownership
  input wire logic ctrl_write_request,
  input wire logic master_write_reclaim,
  // control configuration and events
  input wire logic [dclc_pkg::DCLC_GATE0_W-1:0] ctrl_periph_gating0,
  input wire logic [NCP-1:0] ctrl_periph_gating,
  input wire logic [1:0] lowpower_mode_bits,
  input wire logic idle_status_signal,
  input wire logic ctrl_wake_irq,
  input wire logic ctrl_nmi,
  input wire logic lowpower_wake,
  input wire logic master_ipc_int,
  input wire logic [1:0] timer_clk_select,
  input wire logic [PRE_W-1:0] timer_prescale,
  input wire logic [PRE_W-1:0] low_speed_prescaler,
  input wire logic [PRE_W-1:0] high_speed_prescaler,
  // master clock enables
  output logic pll_system_clk,
  output logic master_subsys_clk,
  output logic master_cpu_clk,
  output logic [NPER-1:0] master_periph_clk,
  output logic [NCAN-1:0] can_clk,
  output logic first_watchdog,
  output logic analog_sys_clk,
  output logic ctrl_input_clk,
  // control clock enables
  output logic ctrl_core_clk,
  output logic ctrl_periph_clk,
  output logic [NCP-1:0] ctrl_periph_en,
  output logic timer_two_clk,
  output logic low_speed_periph_clk,
  output logic high_speed_periph_clk,
  // status
  output dclc_pkg::dclc_mmode_t master_mode,
  output dclc_pkg::dclc_cmode_t ctrl_mode,
  output logic clock_fail,
  output logic pll_power_down,
  output logic osc_power_down,
  output logic pll_owner_ctrl
);

  // ---------------------------------------------------------------
  // source synchronisers
  // ---------------------------------------------------------------
  logic pll_en;
  logic osc_en;
  logic aux_en;
  logic slow_en;
  logic fast_en;
  logic wake_lvl;

  dclc_edge_sync u_sync_pll (.mclk(mclk), .rst_n(rst_n), .async_in(pll_clk_in),
    .level(), .rise(pll_en));
  dclc_edge_sync u_sync_osc (.mclk(mclk), .rst_n(rst_n), .async_in(osc_clk_a),
    .level(), .rise(osc_en));
  dclc_edge_sync u_sync_aux (.mclk(mclk), .rst_n(rst_n), .async_in(aux_clk_in),
    .level(), .rise(aux_en));
  dclc_edge_sync u_sync_slow (.mclk(mclk), .rst_n(rst_n), .async_in(slow_internal_clk),
    .level(), .rise(slow_en));
  dclc_edge_sync u_sync_fast (.mclk(mclk), .rst_n(rst_n), .async_in(fast_internal_clk),
    .level(), .rise(fast_en));
  dclc_edge_sync u_sync_wake (.mclk(mclk), .rst_n(rst_n), .async_in(lowpower_wake),
    .level(wake_lvl), .rise());

  // ---------------------------------------------------------------
  // missing clock detection and ownership
  // ---------------------------------------------------------------
  logic [dclc_pkg::DCLC_MISS_W-1:0] miss_reg;
  logic [dclc_pkg::DCLC_MISS_W-1:0] miss_next;
  logic fail_reg;
  logic fail_next;
  logic owner_reg;
  logic owner_next;

  always_comb begin
    miss_next = miss_reg;
    fail_next = fail_reg;
    if (osc_en) begin
      miss_next = '0;
    end else if (fast_en && !fail_reg) begin
      miss_next = dclc_pkg::DCLC_MISS_W'(miss_reg + 1'b1);
    end
    if (fast_en && !osc_en && miss_reg >= dclc_pkg::DCLC_MISS_W'(MISS_LIMIT - 1)) begin
      fail_next = 1'h1; // [R25]
    end
    owner_next = owner_reg;
    if (master_write_reclaim) begin
      owner_next = dclc_pkg::DCLC_OWNER_MASTER; // [R18]
    end else if (ctrl_write_request) begin
      owner_next = dclc_pkg::DCLC_OWNER_CTRL; // [R18]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      miss_reg <= '0;
      fail_reg <= 1'h0;
      owner_reg <= dclc_pkg::DCLC_OWNER_MASTER;
    end else begin
      miss_reg <= miss_next;
      fail_reg <= fail_next;
      owner_reg <= owner_next;
    end
  end

  // fast internal clock replaces the pll output once the source is lost
  logic pll_sys_en;
  assign pll_sys_en = fail_reg ? fast_en : pll_en; // [R25]

  // ---------------------------------------------------------------
  // master mode machine
  // ---------------------------------------------------------------
  dclc_pkg::dclc_mmode_t mmode_reg;
  dclc_pkg::dclc_mmode_t mmode_next;

  always_comb begin
    mmode_next = mmode_reg;
    case (mmode_reg)
      dclc_pkg::DCLC_M_RUN: begin
        if (wait_for_interrupt_instr) begin
          mmode_next = deep_sleep_select ? dclc_pkg::DCLC_M_DEEP
                                         : dclc_pkg::DCLC_M_SLEEP; // [R05]
        end
      end
      dclc_pkg::DCLC_M_SLEEP: begin
        if (master_wake_irq) begin
          mmode_next = sleep_on_exit ? dclc_pkg::DCLC_M_ISR_SLEEP
                                     : dclc_pkg::DCLC_M_RUN; // [R06] [R10]
        end
      end
      dclc_pkg::DCLC_M_DEEP: begin
        if (master_wake_irq) begin
          mmode_next = sleep_on_exit ? dclc_pkg::DCLC_M_ISR_DEEP
                                     : dclc_pkg::DCLC_M_RUN; // [R06] [R10]
        end
      end
      dclc_pkg::DCLC_M_ISR_SLEEP: begin
        if (master_isr_done) begin
          mmode_next = dclc_pkg::DCLC_M_SLEEP; // [R10]
        end
      end
      dclc_pkg::DCLC_M_ISR_DEEP: begin
        if (master_isr_done) begin
          mmode_next = dclc_pkg::DCLC_M_DEEP; // [R10]
        end
      end
      default: begin
        mmode_next = dclc_pkg::DCLC_M_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mmode_reg <= dclc_pkg::DCLC_M_RUN;
    end else begin
      mmode_reg <= mmode_next;
    end
  end

  logic m_sleep;
  logic m_deep;
  assign m_sleep = (mmode_reg == dclc_pkg::DCLC_M_SLEEP);
  assign m_deep = (mmode_reg == dclc_pkg::DCLC_M_DEEP);

  // ---------------------------------------------------------------
  // master clock dividers
  // ---------------------------------------------------------------
  logic mss_en;
  logic ds_src_en;
  logic ds_div_en;
  logic ds_clk_en;

  dclc_pulse_div #(.W(DIV_W)) u_div_mss (.mclk(mclk), .rst_n(rst_n),
    .en_in(pll_sys_en), .div(master_clk_divider), .en_out(mss_en)); // [R01]

  always_comb begin
    case (deep_sleep_src_sel)
      dclc_pkg::DCLC_DS_SRC_SLOW: ds_src_en = slow_en; // [R13]
      dclc_pkg::DCLC_DS_SRC_FAST: ds_src_en = fast_en; // [R13]
      dclc_pkg::DCLC_DS_SRC_OSC: ds_src_en = osc_en; // [R13]
      default: ds_src_en = 1'h0;
    endcase
  end

  dclc_pulse_div #(.W(DIV_W)) u_div_ds (.mclk(mclk), .rst_n(rst_n),
    .en_in(ds_src_en), .div(deep_sleep_div), .en_out(ds_div_en)); // [R14]
  dclc_pulse_div #(.W(DIV_W)) u_div_dsm (.mclk(mclk), .rst_n(rst_n),
    .en_in(ds_div_en), .div(master_clk_divider), .en_out(ds_clk_en)); // [R14]

  // ---------------------------------------------------------------
  // control mode machine
  // ---------------------------------------------------------------
  dclc_pkg::dclc_cmode_t cmode_reg;
  dclc_pkg::dclc_cmode_t cmode_next;
  logic [dclc_pkg::DCLC_QUAL_W:0] qual_reg;
  logic [dclc_pkg::DCLC_QUAL_W:0] qual_next;
  logic [dclc_pkg::DCLC_QUAL_W-1:0] qual_len;
  logic idle_prev_reg;
  logic wake_ok;

  assign qual_len = ctrl_periph_gating0[dclc_pkg::DCLC_QUAL_MSB:dclc_pkg::DCLC_QUAL_LSB];
  assign wake_ok = wake_lvl && (qual_reg > {1'b0, qual_len}); // [R27]

  always_comb begin
    cmode_next = cmode_reg;
    qual_next = qual_reg;
    // wake pin must hold for qual_len + 1 oscillator samples
    if (!wake_lvl || cmode_reg != dclc_pkg::DCLC_C_STANDBY) begin
      qual_next = '0;
    end else if (osc_en && !wake_ok) begin
      qual_next = (dclc_pkg::DCLC_QUAL_W+1)'(qual_reg + 1'b1); // [R27]
    end
    case (cmode_reg)
      dclc_pkg::DCLC_C_NORMAL: begin
        if (idle_status_signal && !idle_prev_reg) begin
          cmode_next = (lowpower_mode_bits == dclc_pkg::DCLC_LPM_IDLE)
                       ? dclc_pkg::DCLC_C_IDLE : dclc_pkg::DCLC_C_STANDBY; // [R24]
        end
      end
      dclc_pkg::DCLC_C_IDLE: begin
        if (ctrl_wake_irq || ctrl_nmi) begin
          cmode_next = dclc_pkg::DCLC_C_NORMAL; // [R26]
        end
      end
      dclc_pkg::DCLC_C_STANDBY: begin
        if (wake_ok || master_ipc_int) begin
          cmode_next = dclc_pkg::DCLC_C_NORMAL; // [R27]
        end
      end
      default: begin
        cmode_next = dclc_pkg::DCLC_C_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmode_reg <= dclc_pkg::DCLC_C_NORMAL;
      qual_reg <= '0;
      idle_prev_reg <= 1'h0;
    end else begin
      cmode_reg <= cmode_next;
      qual_reg <= qual_next;
      idle_prev_reg <= idle_status_signal;
    end
  end

  // ---------------------------------------------------------------
  // control derived clocks
  // ---------------------------------------------------------------
  logic c_in_en;
  logic c_per_en;
  logic tmr_src_en;
  logic tmr_en;
  logic lsp_en;
  logic hsp_en;

  assign c_in_en = m_deep ? 1'h0 : pll_sys_en; // [R11]
  assign c_per_en = c_in_en && (cmode_reg != dclc_pkg::DCLC_C_STANDBY); // [R21]

  always_comb begin
    case (timer_clk_select)
      dclc_pkg::DCLC_TMR_SRC_PERIPH: tmr_src_en = c_per_en; // [R22]
      dclc_pkg::DCLC_TMR_SRC_OSC: tmr_src_en = osc_en; // [R22]
      dclc_pkg::DCLC_TMR_SRC_FAST: tmr_src_en = fast_en; // [R22]
      default: tmr_src_en = 1'h0;
    endcase
  end

  dclc_pulse_div #(.W(PRE_W)) u_div_tmr (.mclk(mclk), .rst_n(rst_n),
    .en_in(tmr_src_en), .div(timer_prescale), .en_out(tmr_en)); // [R22]
  dclc_pulse_div #(.W(PRE_W)) u_div_lsp (.mclk(mclk), .rst_n(rst_n),
    .en_in(c_per_en), .div(low_speed_prescaler), .en_out(lsp_en)); // [R23]
  dclc_pulse_div #(.W(PRE_W)) u_div_hsp (.mclk(mclk), .rst_n(rst_n),
    .en_in(c_per_en), .div(high_speed_prescaler), .en_out(hsp_en)); // [R23]

  // ---------------------------------------------------------------
  // gated clock outputs
  // ---------------------------------------------------------------
  logic [NPER-1:0] gate_sel;
  logic [NCAN-1:0] can_next;
  logic [NCAN-1:0] can_reg;
  logic [NPER-1:0] per_next;
  logic [NPER-1:0] per_reg;
  logic [NCP-1:0] cp_next;
  logic [NCP-1:0] cp_reg;
  logic [12:0] misc_next;
  logic [12:0] misc_reg;
  logic per_base;

  always_comb begin
    gate_sel = run_gating_cfg; // [R03]
    if (m_sleep && auto_gating_select) begin
      gate_sel = sleep_gating_cfg; // [R08]
    end else if (m_deep && auto_gating_select) begin
      gate_sel = deep_sleep_gating_cfg; // [R12]
    end
    // sleep keeps the run rate; deep sleep switches to the deep chain
    per_base = m_deep ? ds_clk_en : mss_en; // [R09] [R14]
    // each gate acts on a whole enable pulse, so no runt can escape
    per_next = {NPER{per_base}} & gate_sel & device_config_enable; // [R04] [R28]
    for (int i = 0; i < NCAN; i++) begin
      case (can_clk_sel[2*i +: 2])
        dclc_pkg::DCLC_CAN_SRC_MSS: can_next[i] = mss_en; // [R02]
        dclc_pkg::DCLC_CAN_SRC_OSC: can_next[i] = osc_en; // [R02]
        dclc_pkg::DCLC_CAN_SRC_AUX: can_next[i] = aux_en; // [R02]
        default: can_next[i] = 1'h0;
      endcase
    end
    cp_next = {NCP{c_per_en}} & ctrl_periph_gating; // [R19]
    misc_next[0] = pll_sys_en;
    misc_next[1] = m_deep ? 1'h0 : mss_en; // [R11]
    misc_next[2] = (mmode_reg == dclc_pkg::DCLC_M_RUN ||
                    mmode_reg == dclc_pkg::DCLC_M_ISR_SLEEP ||
                    mmode_reg == dclc_pkg::DCLC_M_ISR_DEEP) && mss_en; // [R01] [R07]
    misc_next[3] = osc_en; // [R02]
    misc_next[4] = c_in_en; // [R11]
    misc_next[5] = c_in_en; // [R11]
    misc_next[6] = c_in_en && (cmode_reg == dclc_pkg::DCLC_C_NORMAL); // [R20] [R21]
    misc_next[7] = c_per_en; // [R20] [R21]
    misc_next[8] = tmr_en;
    misc_next[9] = lsp_en;
    misc_next[10] = hsp_en;
    misc_next[11] = m_deep; // [R11]
    misc_next[12] = m_deep && (deep_sleep_src_sel != dclc_pkg::DCLC_DS_SRC_OSC); // [R15]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      per_reg <= '0;
      can_reg <= '0;
      cp_reg <= '0;
      misc_reg <= '0;
    end else begin
      per_reg <= per_next;
      can_reg <= can_next;
      cp_reg <= cp_next;
      misc_reg <= misc_next;
    end
  end

  assign master_periph_clk = per_reg;
  assign can_clk = can_reg;
  assign ctrl_periph_en = cp_reg;
  assign pll_system_clk = misc_reg[0];
  assign master_subsys_clk = misc_reg[1];
  assign master_cpu_clk = misc_reg[2];
  assign first_watchdog = misc_reg[3];
  assign analog_sys_clk = misc_reg[4];
  assign ctrl_input_clk = misc_reg[5];
  assign ctrl_core_clk = misc_reg[6];
  assign ctrl_periph_clk = misc_reg[7];
  assign timer_two_clk = misc_reg[8];
  assign low_speed_periph_clk = misc_reg[9];
  assign high_speed_periph_clk = misc_reg[10];
  assign pll_power_down = misc_reg[11];
  assign osc_power_down = misc_reg[12];
  assign master_mode = mmode_reg;
  assign ctrl_mode = cmode_reg;
  assign clock_fail = fail_reg;
  assign pll_owner_ctrl = owner_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_wfi_entry: assert property ( // [R05]
    mmode_reg == dclc_pkg::DCLC_M_RUN && wait_for_interrupt_instr && deep_sleep_select
    |=> mmode_reg == dclc_pkg::DCLC_M_DEEP ##1 !master_cpu_clk)
    else $error("wfi with deep select did not stop cpu in deep sleep");
  chk_sleep_cpu_off: assert property ( // [R07]
    m_sleep |=> !master_cpu_clk)
    else $error("master cpu clock ran in sleep");
  chk_deep_ctrl_off: assert property ( // [R11]
    m_deep && $past(m_deep) |=> !ctrl_input_clk && !analog_sys_clk && pll_power_down)
    else $error("control or analog clock ran in deep sleep");
  chk_periph_present: assert property ( // [R04]
    1'b1 |=> (master_periph_clk & ~$past(device_config_enable)) == '0)
    else $error("absent peripheral received a clock");
  chk_osc_pdown: assert property ( // [R15]
    m_deep && deep_sleep_src_sel == dclc_pkg::DCLC_DS_SRC_SLOW |=> osc_power_down)
    else $error("oscillator kept running with internal deep source");
  chk_idle_core: assert property ( // [R21]
    cmode_reg == dclc_pkg::DCLC_C_IDLE && c_in_en |=> ctrl_periph_clk && !ctrl_core_clk)
    else $error("idle clock states wrong");
  chk_standby_off: assert property ( // [R21]
    cmode_reg == dclc_pkg::DCLC_C_STANDBY |=> !ctrl_core_clk && !ctrl_periph_clk
    && ctrl_periph_en == '0)
    else $error("control clock ran in standby");
  chk_idle_exit: assert property ( // [R26]
    cmode_reg == dclc_pkg::DCLC_C_IDLE && ctrl_nmi |=> cmode_reg == dclc_pkg::DCLC_C_NORMAL)
    else $error("nmi did not end idle");
  chk_fail_subst: assert property ( // [R25]
    fail_reg && fast_en |=> pll_system_clk)
    else $error("fast clock not substituted after clock failure");
  chk_pll_owner: assert property ( // [R18]
    ctrl_write_request && !master_write_reclaim |=> pll_owner_ctrl)
    else $error("control request did not take pll ownership");
  chk_pll_reclaim: assert property ( // [R18]
    master_write_reclaim |=> !pll_owner_ctrl)
    else $error("master reclaim did not return pll ownership");

endmodule : dclc_clock_control
`default_nettype wire

// >>> core/dclc_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dclc_edge_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pin side
  input wire logic async_in,
  // synchronised level and rising-edge pulse
  output logic level,
  output logic rise
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic s1_next;
  logic s2_next;
  logic s3_next;

  always_comb begin
    s1_next = async_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign level = s2_reg;
  assign rise = s2_reg & ~s3_reg;

endmodule : dclc_edge_sync
`default_nettype wire

// >>> core/dclc_pkg.sv
package dclc_pkg;

  // ---------------------------------------------------------------
  // master subsystem power modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DCLC_M_RUN       = 3'h0,
    DCLC_M_SLEEP     = 3'h1,
    DCLC_M_DEEP      = 3'h2,
    DCLC_M_ISR_SLEEP = 3'h3,
    DCLC_M_ISR_DEEP  = 3'h4
  } dclc_mmode_t;

  // ---------------------------------------------------------------
  // control subsystem power modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DCLC_C_NORMAL  = 2'h0,
    DCLC_C_IDLE    = 2'h1,
    DCLC_C_STANDBY = 2'h2
  } dclc_cmode_t;

  // ---------------------------------------------------------------
  // field encodings and positions
  // ---------------------------------------------------------------
  localparam logic [1:0] DCLC_DS_SRC_SLOW = 2'h0;
  localparam logic [1:0] DCLC_DS_SRC_FAST = 2'h1;
  localparam logic [1:0] DCLC_DS_SRC_OSC = 2'h2;
  localparam logic [1:0] DCLC_CAN_SRC_MSS = 2'h0;
  localparam logic [1:0] DCLC_CAN_SRC_OSC = 2'h1;
  localparam logic [1:0] DCLC_CAN_SRC_AUX = 2'h2;
  localparam logic [1:0] DCLC_TMR_SRC_PERIPH = 2'h0;
  localparam logic [1:0] DCLC_TMR_SRC_OSC = 2'h1;
  localparam logic [1:0] DCLC_TMR_SRC_FAST = 2'h2;
  localparam logic [1:0] DCLC_LPM_IDLE = 2'h0;
  localparam int DCLC_QUAL_LSB = 2;
  localparam int DCLC_QUAL_MSB = 7;
  localparam int DCLC_QUAL_W = DCLC_QUAL_MSB - DCLC_QUAL_LSB + 1;
  localparam int DCLC_GATE0_W = 8;

  // ---------------------------------------------------------------
  // timing counts and reset values
  // ---------------------------------------------------------------
  localparam int DCLC_MISS_LIMIT = 16;
  localparam int DCLC_MISS_W = 5;
  localparam logic DCLC_OWNER_MASTER = 1'h0;
  localparam logic DCLC_OWNER_CTRL = 1'h1;

endpackage : dclc_pkg

// >>> core/dclc_pulse_div.sv
`timescale 1ns/10ps
`default_nettype none
module dclc_pulse_div #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // source enable and ratio (divide by div + 1)
  input wire logic en_in,
  input wire logic [W-1:0] div,
  // divided enable, one cycle per pulse
  output logic en_out
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic out_reg;
  logic out_next;

  // whole input pulses only, so the output never carries a runt
  always_comb begin
    cnt_next = cnt_reg;
    out_next = 1'h0;
    if (en_in) begin
      if (cnt_reg >= div) begin
        cnt_next = '0;
        out_next = 1'h1;
      end else begin
        cnt_next = W'(cnt_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      out_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign en_out = out_reg;

endmodule : dclc_pulse_div
`default_nettype wire

// >>> verification/dclc_clock_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dclc_clock_control_tb;
  logic mclk, rst_n, kill, pll_clk_in, osc_clk_a, aux_clk_in, slow_internal_clk, fast_internal_clk;
  logic [7:0] run_gating_cfg, sleep_gating_cfg, deep_sleep_gating_cfg, device_config_enable;
  logic [3:0] master_clk_divider, deep_sleep_div;
  logic [1:0] deep_sleep_src_sel, lowpower_mode_bits, timer_clk_select;
  logic [7:0] ctrl_periph_gating0, master_periph_clk, seen;
  logic [15:0] ctrl_periph_gating, pe;
  logic [9:0] o, sx;
  logic [8:0] ev;
  logic [2:0] lv;
  logic master_cpu_clk, ctrl_core_clk, ctrl_periph_clk, clock_fail, pll_power_down;
  logic osc_power_down, pll_owner_ctrl, seen_cpu, seen_core, seen_cp, wk;
  dclc_pkg::dclc_mmode_t master_mode;
  dclc_pkg::dclc_cmode_t ctrl_mode;
  int n_fail, cmp_count, tcnt;

  dclc_src_model src (.stop(kill | osc_power_down), .pll_clk_in, .osc_clk_a, .aux_clk_in,
    .slow_internal_clk, .fast_internal_clk);

  dclc_clock_control DUT (.mclk, .rst_n, .pll_clk_in, .osc_clk_a, .aux_clk_in,
    .slow_internal_clk, .fast_internal_clk, .run_gating_cfg, .sleep_gating_cfg,
    .deep_sleep_gating_cfg, .device_config_enable, .auto_gating_select(lv[0]),
    .master_clk_divider, .deep_sleep_src_sel, .deep_sleep_div, .can_clk_sel(4'h9),
    .wait_for_interrupt_instr(ev[0]), .deep_sleep_select(lv[1]), .sleep_on_exit(lv[2]),
    .master_wake_irq(ev[1]), .master_isr_done(ev[2]), .ctrl_write_request(ev[3]),
    .master_write_reclaim(ev[4]), .ctrl_periph_gating0, .ctrl_periph_gating,
    .lowpower_mode_bits, .idle_status_signal(ev[5]), .ctrl_wake_irq(ev[6]), .ctrl_nmi(ev[8]),
    .lowpower_wake(wk), .master_ipc_int(ev[7]), .timer_clk_select, .timer_prescale(3'h0),
    .low_speed_prescaler(3'h0), .high_speed_prescaler(3'h0), .pll_system_clk(o[0]),
    .master_subsys_clk(o[1]), .master_cpu_clk, .master_periph_clk, .can_clk(o[9:8]),
    .first_watchdog(o[2]), .analog_sys_clk(o[3]), .ctrl_input_clk(o[4]), .ctrl_core_clk,
    .ctrl_periph_clk, .ctrl_periph_en(pe), .timer_two_clk(o[5]), .low_speed_periph_clk(o[6]),
    .high_speed_periph_clk(o[7]), .master_mode,
    .ctrl_mode, .clock_fail, .pll_power_down, .osc_power_down, .pll_owner_ctrl);

  // --------------------------------
  // access tasks
  // --------------------------------
  // cycles pass with enable pulses collected
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      seen = seen | master_periph_clk;
      sx = sx | o;
      seen_cpu = seen_cpu | master_cpu_clk;
      seen_core = seen_core | ctrl_core_clk;
      seen_cp = seen_cp | (ctrl_periph_clk & (&pe));
    end
  endtask : cyc
  task automatic clr;
    {seen, sx, seen_cpu, seen_core, seen_cp} = 21'h00000;
  endtask : clr
  task automatic pulse(input int b);
    ev[b] = 1'b1;
    cyc(1);
    ev = 9'h000;
    cyc(1);
  endtask : pulse
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // --------------------------------
  // clock, timeout and tests
  // --------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tcnt++;
    if (tcnt == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    {rst_n, kill, wk, ev, lv, lowpower_mode_bits, timer_clk_select} = 19'h00000;
    {run_gating_cfg, sleep_gating_cfg, deep_sleep_gating_cfg} = 24'h0FF03C;
    {device_config_enable, ctrl_periph_gating0, ctrl_periph_gating} = 32'h6604FFFF;
    {master_clk_divider, deep_sleep_div, deep_sleep_src_sel} = 10'h044;
    {n_fail, cmp_count, tcnt} = '0;
    clr;
    cyc(2);
    rst_n = 1'b1;
    clr;
    cyc(60);
    chk(seen, 8'h06);
    chk({seen_cpu, clock_fail, 5'h00, pll_owner_ctrl}, 8'h80);
    chk(sx[7:0], 8'hFF);
    chk({6'h00, sx[9:8]}, 8'h03);
    lv = 3'h1;
    pulse(0);
    chk(8'(master_mode), 8'(dclc_pkg::DCLC_M_SLEEP));
    clr;
    cyc(60);
    chk({seen_cpu, 1'b0, seen[6:1]}, 8'h30);
    pulse(1);
    chk(8'(master_mode), 8'(dclc_pkg::DCLC_M_RUN));
    lowpower_mode_bits = 2'h1;
    pulse(5);
    chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_STANDBY));
    lv = 3'h7;
    pulse(0);
    chk({6'h00, pll_power_down, osc_power_down}, 8'h03);
    clr;
    cyc(80);
    chk({seen_cpu, 1'b0, seen[6:1]}, 8'h12);
    chk(sx[7:0] & 8'hFA, 8'h00);
    pulse(1);
    chk(8'(master_mode), 8'(dclc_pkg::DCLC_M_ISR_DEEP));
    pulse(2);
    chk(8'(master_mode), 8'(dclc_pkg::DCLC_M_DEEP));
    lv = 3'h0;
    pulse(1);
    chk(8'(master_mode), 8'(dclc_pkg::DCLC_M_RUN));
    pulse(7);
    lowpower_mode_bits = 2'h0;
    pulse(3);
    chk({7'h00, pll_owner_ctrl}, 8'h01);
    pulse(4);
    chk({7'h00, pll_owner_ctrl}, 8'h00);
    for (int b = 6; b <= 8; b += 2) begin
      pulse(5);
      chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_IDLE));
      clr;
      cyc(30);
      chk({6'h00, seen_core, seen_cp}, 8'h01);
      pulse(b);
      chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_NORMAL));
    end
    lowpower_mode_bits = 2'h1;
    pulse(5);
    chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_STANDBY));
    clr;
    cyc(30);
    chk({6'h00, seen_core, seen_cp}, 8'h00);
    pulse(7);
    chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_NORMAL));
    pulse(5);
    wk = 1'b1;
    cyc(3);
    chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_STANDBY));
    cyc(30);
    chk(8'(ctrl_mode), 8'(dclc_pkg::DCLC_C_NORMAL));
    wk = 1'b0;
    kill = 1'b1;
    cyc(250);
    chk({7'h00, clock_fail}, 8'h01);
    stop_test;
  end
endmodule : dclc_clock_control_tb
`default_nettype wire

// >>> verification/dclc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module dclc_src_model (
  // oscillator stop request
  input wire logic stop,
  // source clocks, free-running except the oscillator, which stops on stop
  output logic pll_clk_in,
  output logic osc_clk_a,
  output logic aux_clk_in,
  output logic slow_internal_clk,
  output logic fast_internal_clk
);
  // periods above four mclk cycles, unrelated to mclk
  initial begin
    {pll_clk_in, osc_clk_a, aux_clk_in, slow_internal_clk, fast_internal_clk} = 5'h00;
  end
  always #23 pll_clk_in = ~pll_clk_in;
  always #37 osc_clk_a = stop ? 1'b0 : ~osc_clk_a;
  always #31 aux_clk_in = ~aux_clk_in;
  always #97 slow_internal_clk = ~slow_internal_clk;
  always #53 fast_internal_clk = ~fast_internal_clk;
endmodule : dclc_src_model
`default_nettype wire
